/* design/can_vec_pkg.sv */
package can_vec_pkg;

    // ==========================================
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] VEC_ADDR = 8'h00;
    localparam int WORD_LSB = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================
    // Vector fields
    localparam int FILT_W = 5;
    localparam int CODE_W = 7;
    localparam int FILT_LSB = 8;
    localparam int CODE_LSB = 0;
    localparam logic [31:0] RSVD_MASK = 32'hffff_e080;
    localparam logic [FILT_W-1:0] FILT_RESET = 5'h00;

    // ==========================================
    // Interrupt source codes
    localparam logic [CODE_W-1:0] CODE_RSV_LO = 7'h20;
    localparam logic [CODE_W-1:0] CODE_NONE = 7'h40;
    localparam logic [CODE_W-1:0] CODE_BUS_ERROR = 7'h41;
    localparam logic [CODE_W-1:0] CODE_WAKEUP = 7'h42;
    localparam logic [CODE_W-1:0] CODE_RX_OVERFLOW = 7'h43;
    localparam logic [CODE_W-1:0] CODE_ADDR_ERROR = 7'h44;
    localparam logic [CODE_W-1:0] CODE_BANDWIDTH = 7'h45;
    localparam logic [CODE_W-1:0] CODE_TIMESTAMP = 7'h46;
    localparam logic [CODE_W-1:0] CODE_MODE_CHANGE = 7'h47;
    localparam logic [CODE_W-1:0] CODE_INVALID_MSG = 7'h48;

    typedef struct packed {
        logic [FILT_W-1:0] matched_filter_index;
        logic [CODE_W-1:0] interrupt_source_code;
    } can_vec_s;

    // Listed from highest to lowest service priority
    typedef struct packed {
        logic bus_error_flag;
        logic wakeup_flag;
        logic rx_fifo_overflow_flag;
        logic address_error;
        logic bandwidth_error;
        logic timestamp_timer_flag;
        logic mode_change_flag;
        logic invalid_message_flag;
    } can_events_s;

    function automatic logic [31:0] pack_vector(input can_vec_s v);
        logic [31:0] w;
        w = '0;
        w[FILT_LSB +: FILT_W] = v.matched_filter_index;
        w[CODE_LSB +: CODE_W] = v.interrupt_source_code;
        return w;
    endfunction

endpackage

/* design/can_interrupt_code_vector.sv */
// Operation
// - Filter index reports matched acceptance filter number 0..31 in plain binary.
// - FIFO n pending gives code n; codes 0x20..0x3f never produced.
// - Nothing pending gives code 1000000.
// - Bus error 1000001, wake-up 1000010, receive overflow 1000011.
// - Address error 1000100, bandwidth error 1000101, both raise system error flag.
// - Timestamp 1000110, mode change 1000111, invalid message 1001000; higher never produced.
// - Bits 31..13 and bit 7 read zero; writes have no effect.
// - Fields read-only; reset gives index 00000 and code 1000000.
module can_interrupt_code_vector #(
    parameter int NUM_FIFOS = 32
) (
    input wire logic aclk, // Peripheral clock
    input wire logic aresetn, // Sync reset, active low
    input wire logic [can_vec_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data, ignored
    input wire logic [3:0] s_axi_wstrb, // Write strobes, ignored
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [can_vec_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [31:0] fifo_interrupt_status_word, // Per-FIFO pending flags
    input wire can_vec_pkg::can_events_s events, // Module event flags
    input wire logic filter_hit_valid, // Pulse: a filter matched
    input wire logic [can_vec_pkg::FILT_W-1:0] filter_hit_index, // Number of that filter
    output can_vec_pkg::can_vec_s vec, // Current vector fields
    output logic system_error_flag // Address or bandwidth error pending
);
    import can_vec_pkg::*;

    if (NUM_FIFOS < 1 || NUM_FIFOS > 32) begin : g_bad_fifos
        $error("NUM_FIFOS must be 1 to 32");
    end

    // ==========================================
    // Source encoding
    logic [CODE_W-1:0] next_code;
    logic [CODE_W-1:0] source_code;
    logic [FILT_W-1:0] filter_index;

    // One driver for the whole output word
    assign vec = {filter_index, source_code};

    always_comb begin
        next_code = CODE_NONE;
        if (events.bus_error_flag) begin
            next_code = CODE_BUS_ERROR;
        end else if (events.wakeup_flag) begin
            next_code = CODE_WAKEUP;
        end else if (events.rx_fifo_overflow_flag) begin
            next_code = CODE_RX_OVERFLOW;
        end else if (events.address_error) begin
            next_code = CODE_ADDR_ERROR;
        end else if (events.bandwidth_error) begin
            next_code = CODE_BANDWIDTH;
        end else if (events.timestamp_timer_flag) begin
            next_code = CODE_TIMESTAMP;
        end else if (events.mode_change_flag) begin
            next_code = CODE_MODE_CHANGE;
        end else if (events.invalid_message_flag) begin
            next_code = CODE_INVALID_MSG;
        end else begin
            // Downward scan so the lowest pending FIFO wins
            for (int i = NUM_FIFOS - 1; i >= 0; i--) begin
                if (fifo_interrupt_status_word[i]) begin
                    next_code = CODE_W'(i);
                end
            end
        end
    end

    // Code follows flags one cycle later; no software acknowledge here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_code <= CODE_NONE;
        end else begin
            source_code <= next_code;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filter_index <= FILT_RESET;
        end else if (filter_hit_valid) begin
            filter_index <= filter_hit_index;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_error_flag <= 1'b0;
        end else begin
            system_error_flag <= events.address_error | events.bandwidth_error;
        end
    end

    // ==========================================
    // Write channel: accepted and answered, never stored
    logic aw_got;
    logic w_got;
    logic aw_hit;

    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready = !w_got && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            aw_hit <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_got <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            aw_hit <= (s_axi_awaddr >> WORD_LSB) == (VEC_ADDR >> WORD_LSB);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_got <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (s_axi_bvalid) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end else if (aw_got && w_got) begin
            s_axi_bvalid <= 1'b1;
            // Read-only word: write is acknowledged and dropped
            s_axi_bresp <= aw_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ==========================================
    // Read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if ((s_axi_araddr >> WORD_LSB) == (VEC_ADDR >> WORD_LSB)) begin
                s_axi_rdata <= pack_vector(vec);
                s_axi_rresp <= RESP_OKAY;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic higher_than_ts;
    assign higher_than_ts = events.bus_error_flag | events.wakeup_flag | events.rx_fifo_overflow_flag
        | events.address_error | events.bandwidth_error;

    // ==========================================
    // Filter index
    AST_FILTER_LATCH: assert property (
        filter_hit_valid |=> vec.matched_filter_index == $past(filter_hit_index))
        else $error("filter index not captured");
    AST_FILTER_HOLD: assert property (
        !filter_hit_valid |=> $stable(vec.matched_filter_index))
        else $error("filter index moved without a hit");
    AST_FILTER_TOP: assert property (
        filter_hit_valid && filter_hit_index == '1 |=> vec.matched_filter_index == '1)
        else $error("last filter number wrong");
    AST_FILTER_ZERO: assert property (
        filter_hit_valid && filter_hit_index == '0 |=> vec.matched_filter_index == '0)
        else $error("first filter number wrong");

    // ==========================================
    // Source code and priority
    AST_FIFO0_CODE: assert property (
        (events == '0) && fifo_interrupt_status_word[0] |=> vec.interrupt_source_code == '0)
        else $error("FIFO 0 not reported");
    AST_FIFO_TOP: assert property (
        (events == '0) && (fifo_interrupt_status_word == (32'h1 << (NUM_FIFOS - 1)))
        |=> vec.interrupt_source_code == CODE_W'(NUM_FIFOS - 1))
        else $error("highest FIFO not reported");
    AST_FIFO_RANGE: assert property (
        (events == '0) && (fifo_interrupt_status_word != '0) |=> vec.interrupt_source_code < CODE_RSV_LO)
        else $error("FIFO code out of range");
    AST_NO_RSV_LOW: assert property (
        !(vec.interrupt_source_code >= CODE_RSV_LO && vec.interrupt_source_code < CODE_NONE))
        else $error("reserved FIFO range code");
    AST_IDLE_CODE: assert property (
        (events == '0) && (fifo_interrupt_status_word == '0) |=> vec.interrupt_source_code == CODE_NONE)
        else $error("idle code wrong");
    AST_BUS_ERR: assert property (
        events.bus_error_flag |=> vec.interrupt_source_code == CODE_BUS_ERROR)
        else $error("bus error not top priority");
    AST_WAKE: assert property (
        !events.bus_error_flag && events.wakeup_flag |=> vec.interrupt_source_code == CODE_WAKEUP)
        else $error("wake-up code wrong");
    AST_OVERFLOW: assert property (
        events[7:5] == 3'h1 |=> vec.interrupt_source_code == CODE_RX_OVERFLOW)
        else $error("overflow code wrong");
    AST_ADDR_ERR: assert property (
        events[7:4] == 4'h1 |=> vec.interrupt_source_code == CODE_ADDR_ERROR)
        else $error("address error code wrong");
    AST_BANDWIDTH: assert property (
        events[7:3] == 5'h01 |=> vec.interrupt_source_code == CODE_BANDWIDTH)
        else $error("bandwidth error code wrong");
    AST_SYS_ERR: assert property (
        events.address_error ##1 events.address_error |-> system_error_flag)
        else $error("system error flag missing");
    AST_SYS_ERR_BW: assert property (
        events.bandwidth_error |=> system_error_flag)
        else $error("system error flag missing on bandwidth error");
    AST_SYS_ERR_CLR: assert property (
        !events.address_error && !events.bandwidth_error |=> !system_error_flag)
        else $error("system error flag stuck");
    AST_TIMESTAMP: assert property (
        events[7:2] == 6'h01 |=> vec.interrupt_source_code == CODE_TIMESTAMP)
        else $error("timestamp code wrong");
    AST_MODE: assert property (
        events[7:1] == 7'h01 |=> vec.interrupt_source_code == CODE_MODE_CHANGE)
        else $error("mode change code wrong");
    AST_INVALID: assert property (
        events == 8'h01 |=> vec.interrupt_source_code == CODE_INVALID_MSG)
        else $error("invalid message code wrong");
    AST_NO_RSV_HIGH: assert property (
        vec.interrupt_source_code <= CODE_INVALID_MSG)
        else $error("reserved high code");
    AST_TS_OVER_MODE: assert property (
        !higher_than_ts && events.timestamp_timer_flag && events.mode_change_flag
        |=> vec.interrupt_source_code == CODE_TIMESTAMP)
        else $error("priority order broken");
    // Any module event must outrank every FIFO
    AST_EVENT_OVER_FIFO: assert property (
        events != '0 |=> vec.interrupt_source_code >= CODE_BUS_ERROR)
        else $error("FIFO code beat a module event");

    // ==========================================
    // Register bus
    AST_RSVD_ZERO: assert property (
        s_axi_rvalid |-> (s_axi_rdata & RSVD_MASK) == '0)
        else $error("reserved bits not zero");
    AST_RESET_VAL: assert property (
        $past(aresetn) == 1'b0 |-> vec.interrupt_source_code == CODE_NONE
        && vec.matched_filter_index == FILT_RESET)
        else $error("reset value wrong");
    AST_RESET_BUS: assert property (
        $past(aresetn) == 1'b0 |-> !system_error_flag && !s_axi_rvalid && !s_axi_bvalid)
        else $error("bus or flag not idle after reset");
    AST_READ_LAT: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_READ_DATA: assert property (
        s_axi_arvalid && s_axi_arready && ((s_axi_araddr >> WORD_LSB) == (VEC_ADDR >> WORD_LSB))
        |=> s_axi_rdata[FILT_LSB +: FILT_W] == $past(vec.matched_filter_index)
        && s_axi_rdata[CODE_LSB +: CODE_W] == $past(vec.interrupt_source_code))
        else $error("read data not the vector");
    AST_BAD_ADDR: assert property (
        s_axi_arvalid && s_axi_arready && ((s_axi_araddr >> WORD_LSB) != (VEC_ADDR >> WORD_LSB))
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read not refused");
    AST_RVALID_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    AST_BVALID_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    AST_WRITE_LAT: assert property (
        aw_got && w_got && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write answer late");

    COV_BUS_ERR: cover property (events.bus_error_flag ##1 vec.interrupt_source_code == CODE_BUS_ERROR);
    COV_FIFO: cover property (vec.interrupt_source_code < CODE_RSV_LO);
    COV_READ: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
    COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
    COV_FILTER: cover property (filter_hit_valid && filter_hit_index == '1);

endmodule // can_interrupt_code_vector

/* testbench/can_interrupt_code_vector_tb.sv */
module can_interrupt_code_vector_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import can_vec_pkg::*;

    // ==========================================
    // Stimulus and observed signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic hit_valid = 1'b0;
    logic [FILT_W-1:0] hit_idx = '0;
    logic [31:0] wdata = '0;
    logic [31:0] fifo = '0;
    can_events_s ev = '0;
    logic awready, wready, bvalid, arready, rvalid, sys_err;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    can_vec_s vec;
    int err_count = 0;
    int comparisons = 0;
    int i;

    always #20 aclk = ~aclk;

    can_interrupt_code_vector dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fifo_interrupt_status_word(fifo), .events(ev),
        .filter_hit_valid(hit_valid), .filter_hit_index(hit_idx),
        .vec(vec), .system_error_flag(sys_err)
    );

    // ==========================================
    // Bus tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Readies are sampled at the falling edge, where they are settled
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic a_t, w_t, a_d, w_d;
        a_d = 1'b0;
        w_d = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(a_d && w_d)) begin
            @(negedge aclk);
            a_t = !a_d && awready === 1'b1;
            w_t = !w_d && wready === 1'b1;
            @(posedge aclk);
            if (a_t) begin
                awvalid <= 1'b0;
                a_d = 1'b1;
            end
            if (w_t) begin
                wvalid <= 1'b0;
                w_d = 1'b1;
            end
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    // Vector is registered: one edge after the inputs are taken
    task automatic set_src(input logic [31:0] f, input can_events_s e);
        @(posedge aclk);
        fifo <= f;
        ev <= e;
        @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================
    // Tests
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(VEC_ADDR, rd);
        check("reset word", 32'h40, rd);
        check("read resp", RESP_OKAY, resp);
        axi_write(VEC_ADDR, 32'hffffffff);
        check("write resp", RESP_OKAY, resp);
        axi_read(VEC_ADDR | 8'h03, rd);
        check("word after write", 32'h40, rd);
        axi_read(8'h10, rd);
        check("unmapped resp", RESP_SLVERR, resp);
        check("unmapped data", 32'h0, rd);
        axi_write(8'h10, 32'h1f00);
        check("unmapped write resp", RESP_SLVERR, resp);
        // Higher FIFOs also pending, so the lowest must win
        for (i = 0; i < 32; i++) begin
            set_src(32'hffffffff << i, '0);
            check("fifo code", 32'(i), vec.interrupt_source_code);
        end
        for (i = 0; i < 8; i++) begin
            set_src(32'hffffffff, can_events_s'(8'hff >> i));
            check("event code", 32'h41 + 32'(i), vec.interrupt_source_code);
            check("system error", 32'(i < 5), sys_err);
        end
        set_src('0, '0);
        check("idle code", 32'h40, vec.interrupt_source_code);
        for (i = 0; i < 2; i++) begin
            @(posedge aclk);
            hit_idx <= (i == 0) ? 5'h00 : 5'h1f;
            hit_valid <= 1'b1;
            @(posedge aclk);
            hit_valid <= 1'b0;
            hit_idx <= 5'h0a;
            @(negedge aclk);
            axi_read(VEC_ADDR, rd);
            check("filter word", (i == 0) ? 32'h0040 : 32'h1f40, rd);
        end
        @(posedge aclk);
        aresetn <= 1'b0;
        ev <= 8'hff;
        @(posedge aclk);
        @(negedge aclk);
        check("mid reset vector", {FILT_RESET, CODE_NONE}, vec);
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        @(negedge aclk);
        check("code after reset", 32'h41, vec.interrupt_source_code);
        tally_and_finish();
    end

    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
endmodule // can_interrupt_code_vector_tb
